// ---- rtl/tsp_top.sv ----
`timescale 1ns/1ps
// Functional notes
// [R1] Device always masters and drives the clock; SCLK_OE is set only while the priority is nonzero.
// [R2] Mode bits pick clock, out, in, both.
// [R3] Service code 11 starts; others do nothing.
// [R4] Data out above, data in below clock.
// [R5] Edge setup value selects clock polarity.
// [R6] Direction bit: lsb first or msb first.
// [R7] Half period counts timer base ticks.
// [R8] Bit counter loads, decrements, ends with request.
// [R9] Full 16-bit length loads the counter.
// [R10] Shift out one end, in other.
// [R11] No justification of the data word.
// [R12] Host touches data only between transfers.
// [R13] Host follows the documented setup order.
// [R14] Later transfers need data and code 11.
// [R15] Priority zero disables, nonzero lets it run.
// [R16] Interrupt enable gates the completion request.
// [R17] Unused data channels stay free.
// [R18] Output changes after edge, input opposite edge.
// [R19] Idle clock holds polarity level, no edges.
module tsp_top (
	input  wire logic        CLK,       // Bus clock.
	input  wire logic        SYS_RST,   // Asynchronous reset, active high.
	input  wire logic        LINK_CLK,  // Timer base clock that paces the link.
	input  wire logic        PSEL,      // APB select.
	input  wire logic        PENABLE,   // APB access phase.
	input  wire logic        PWRITE,    // APB write.
	input  wire logic [7:0]  PADDR,     // APB byte address.
	input  wire logic [31:0] PWDATA,    // APB write data.
	output logic      [31:0] PRDATA,    // APB read data.
	output logic             PREADY,    // APB ready.
	output logic             PSLVERR,   // APB error on unmapped address.
	output logic             SCLK_O,    // Serial clock level.
	output logic             SCLK_OE,   // Serial clock drive enable.
	output logic             SDO_O,     // Serial data out level.
	output logic             SDO_OE,    // Serial data out drive enable.
	input  wire logic        SDI,       // Serial data in pin.
	output logic             IRQ        // Completion interrupt, active high.
);

	// Bus domain registers.
	logic [8:0]  setup_reg;             // Channel edge setup.
	logic        dir_reg;               // Shift direction.
	logic [1:0]  mode_reg;              // Sequence mode bits.
	logic [1:0]  prio_reg;              // Channel priority.
	logic        ie_reg;                // Interrupt enable.
	logic [1:0]  srv_reg;               // Service request code.
	logic [15:0] half_reg;              // Half period.
	logic [15:0] len_reg;               // Transfer length.
	logic [15:0] data_reg;              // Host view of the shift word.
	logic        busy_reg;              // Transfer running.
	logic        done_reg;              // Sticky completion flag.
	logic        irq_reg;               // Registered interrupt line.
	logic        start_tgl_reg;         // Toggles once per start.
	logic [31:0] prdata_reg;            // Read data captured in setup.
	logic [2:0]  dn_sync_reg;           // Done toggle synchroniser.
	logic        dn_seen_reg;           // Last accepted done toggle.
	logic        done_evt;              // One-cycle completion event.
	logic        hit;                   // Address is mapped.
	logic        wr_acc;                // Write access phase to a mapped address.
	logic        take_start;            // Start request accepted this cycle.
	logic [31:0] rd_mux;                // Read mux.
	tsp_pkg::tsp_cfg_t cfg;             // Settings handed to the link.

	// Link domain registers.
	logic [1:0]  lrst_reg;              // Link reset synchroniser.
	logic        lrst;                  // Link reset.
	logic [2:0]  st_sync_reg;           // Start toggle synchroniser.
	logic        st_seen_reg;           // Last accepted start toggle.
	logic        start_evt;             // One-cycle start event.
	logic [2:0]  pol_sync_reg;          // Idle level synchroniser.
	logic        pol_lvl_reg;           // Settled idle level.
	logic [2:0]  sdi_sync_reg;          // Data in pin synchroniser.
	logic        sdi_lvl_reg;           // Settled data in level.
	tsp_pkg::tsp_lnk_state_t state_reg; // Engine state.
	logic [15:0] half_cnt_reg;          // Half period down counter.
	logic [15:0] bit_cnt_reg;           // Remaining bits.
	logic [15:0] word_reg;              // Shift word in flight.
	logic        ldir_reg;              // Direction taken at start.
	logic [1:0]  lmode_reg;             // Mode taken at start.
	logic [15:0] lhalf_reg;             // Half period reload taken at start.
	logic        lidle_reg;             // Idle level taken at start.
	logic        in_bit_reg;            // Bit sampled at the mid edge.
	logic        sclk_reg;              // Serial clock.
	logic        sdo_reg;               // Serial data out.
	logic        done_tgl_reg;          // Toggles once per completed transfer.
	logic        idle_hi;               // Falling-valid setup idles high.
	logic        half_end;              // Half period expires this cycle.
	logic [15:0] half_load;             // Reload value for the half counter.
	logic        shift_in;              // Bit entering the word.

	// Zero-wait slave: every access completes in its first access cycle.
	assign PREADY  = 1'b1;
	assign hit     = (PADDR == tsp_pkg::OFF_CTRL) || (PADDR == tsp_pkg::OFF_HALF) ||
	                 (PADDR == tsp_pkg::OFF_LEN)  || (PADDR == tsp_pkg::OFF_DATA) ||
	                 (PADDR == tsp_pkg::OFF_STAT);
	assign PSLVERR = PSEL && PENABLE && !hit;
	assign wr_acc  = PSEL && PENABLE && PWRITE && hit;
	assign PRDATA  = prdata_reg;

	// A pending start only launches once the clock channel has a priority.
	assign take_start = (srv_reg == tsp_pkg::SRV_START) && (prio_reg != tsp_pkg::PRIO_OFF) && //R3
	                    !busy_reg; //R15

	// Read mux; unused bits read as zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (PADDR)
			tsp_pkg::OFF_CTRL: begin
				rd_mux[tsp_pkg::CTRL_SETUP_LSB +: 9] = setup_reg;
				rd_mux[tsp_pkg::CTRL_DIR]            = dir_reg;
				rd_mux[tsp_pkg::CTRL_MODE_LSB +: 2]  = mode_reg;
				rd_mux[tsp_pkg::CTRL_PRIO_LSB +: 2]  = prio_reg;
				rd_mux[tsp_pkg::CTRL_IE]             = ie_reg;
				rd_mux[tsp_pkg::CTRL_SRV_LSB +: 2]   = srv_reg;
			end
			tsp_pkg::OFF_HALF: rd_mux[15:0] = half_reg;
			tsp_pkg::OFF_LEN:  rd_mux[15:0] = len_reg;
			tsp_pkg::OFF_DATA: rd_mux[15:0] = data_reg;
			tsp_pkg::OFF_STAT: begin
				rd_mux[tsp_pkg::STAT_DONE] = done_reg;
				rd_mux[tsp_pkg::STAT_BUSY] = busy_reg;
				rd_mux[tsp_pkg::STAT_PEND] = srv_reg == tsp_pkg::SRV_START;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is latched in the setup cycle so PRDATA comes from a flip-flop.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			prdata_reg <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			prdata_reg <= rd_mux;
		end
	end

	// Configuration registers. The link copies length, half period, direction, mode and idle level at start,
	// so the engine sees changes on the next transfer; priority, mode and enable act at once on the OE pins and IRQ.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			setup_reg <= tsp_pkg::SETUP_RST;
			dir_reg   <= 1'b0;
			mode_reg  <= 2'h0;
			prio_reg  <= tsp_pkg::PRIO_OFF;
			ie_reg    <= 1'b0;
			half_reg  <= tsp_pkg::HALF_RST;
			len_reg   <= tsp_pkg::LEN_RST;
		end else if (wr_acc && PADDR == tsp_pkg::OFF_CTRL) begin
			setup_reg <= PWDATA[tsp_pkg::CTRL_SETUP_LSB +: 9];
			dir_reg   <= PWDATA[tsp_pkg::CTRL_DIR];
			mode_reg  <= PWDATA[tsp_pkg::CTRL_MODE_LSB +: 2];
			prio_reg  <= PWDATA[tsp_pkg::CTRL_PRIO_LSB +: 2];
			ie_reg    <= PWDATA[tsp_pkg::CTRL_IE];
		end else if (wr_acc && PADDR == tsp_pkg::OFF_HALF) begin
			half_reg <= PWDATA[15:0];
		end else if (wr_acc && PADDR == tsp_pkg::OFF_LEN) begin
			len_reg <= PWDATA[15:0]; //R9
		end
	end

	// Service code: an accepted start returns it to no request; codes 01 and
	// 10 are stored but trigger nothing.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			srv_reg <= tsp_pkg::SRV_NONE;
		end else if (wr_acc && PADDR == tsp_pkg::OFF_CTRL) begin
			srv_reg <= PWDATA[tsp_pkg::CTRL_SRV_LSB +: 2];
		end else if (take_start) begin
			srv_reg <= tsp_pkg::SRV_NONE; //R3
		end
	end

	// Start handshake and busy tracking.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			start_tgl_reg <= 1'b0;
			busy_reg      <= 1'b0;
		end else if (take_start) begin
			start_tgl_reg <= !start_tgl_reg; //R3
			busy_reg      <= 1'b1;
		end else if (done_evt) begin
			busy_reg <= 1'b0;
		end
	end

	// The shift word is unbuffered: the result replaces host data at completion.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			data_reg <= tsp_pkg::DATA_RST;
		end else if (done_evt) begin
			data_reg <= word_reg; //R11
		end else if (wr_acc && PADDR == tsp_pkg::OFF_DATA) begin
			data_reg <= PWDATA[15:0];
		end
	end

	// Done toggle from the link, three stages, counted once stages two and three agree.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dn_sync_reg <= 3'h0;
			dn_seen_reg <= 1'b0;
		end else begin
			dn_sync_reg <= {dn_sync_reg[1:0], done_tgl_reg};
			if (done_evt) begin
				dn_seen_reg <= dn_sync_reg[2];
			end
		end
	end
	assign done_evt = (dn_sync_reg[1] == dn_sync_reg[2]) && (dn_sync_reg[2] != dn_seen_reg);

	// Sticky completion flag; a new completion beats a clear in the same cycle.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			done_reg <= 1'b0;
		end else if (done_evt) begin
			done_reg <= 1'b1; //R8
		end else if (wr_acc && PADDR == tsp_pkg::OFF_STAT && PWDATA[tsp_pkg::STAT_DONE]) begin
			done_reg <= 1'b0;
		end
	end

	// Interrupt line gated by the enable.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= done_reg && ie_reg; //R16
		end
	end
	assign IRQ = irq_reg;

	// The device is master: the clock pin is driven whenever the channel runs,
	// data out only when the mode uses it, so neighbours stay free otherwise.
	assign SCLK_OE = prio_reg != tsp_pkg::PRIO_OFF; //R1
	assign SDO_OE  = (prio_reg != tsp_pkg::PRIO_OFF) && mode_reg[tsp_pkg::MODE_OUT_BIT]; //R17
	assign cfg     = '{half: half_reg, len: len_reg, dir: dir_reg, mode: mode_reg};
	assign idle_hi = setup_reg == tsp_pkg::EDGE_FALL; //R5

	// Link reset: asserted at once, released on the link clock.
	always_ff @(posedge LINK_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			lrst_reg <= 2'b11;
		end else begin
			lrst_reg <= {lrst_reg[0], 1'b0};
		end
	end
	assign lrst = lrst_reg[1];

	// Start toggle, idle level and data in pin, each through three stages.
	always_ff @(posedge LINK_CLK or posedge lrst) begin
		if (lrst) begin
			st_sync_reg  <= 3'h0;
			st_seen_reg  <= 1'b0;
			pol_sync_reg <= 3'h0;
			pol_lvl_reg  <= 1'b0;
			sdi_sync_reg <= 3'h0;
			sdi_lvl_reg  <= 1'b0;
		end else begin
			st_sync_reg  <= {st_sync_reg[1:0], start_tgl_reg};
			pol_sync_reg <= {pol_sync_reg[1:0], idle_hi};
			sdi_sync_reg <= {sdi_sync_reg[1:0], SDI};
			if (start_evt) begin
				st_seen_reg <= st_sync_reg[2];
			end
			if (pol_sync_reg[1] == pol_sync_reg[2]) begin
				pol_lvl_reg <= pol_sync_reg[2];
			end
			if (sdi_sync_reg[1] == sdi_sync_reg[2]) begin
				sdi_lvl_reg <= sdi_sync_reg[2];
			end
		end
	end
	assign start_evt = (st_sync_reg[1] == st_sync_reg[2]) && (st_sync_reg[2] != st_seen_reg);

	// A zero half period would stall the counter, so it behaves as one.
	assign half_load = (cfg.half == 16'h0000) ? 16'h0000 : cfg.half - 16'h0001;
	assign half_end  = half_cnt_reg == 16'h0000;
	// Output-only and clock-only modes shift zeros in.
	assign shift_in  = lmode_reg[tsp_pkg::MODE_IN_BIT] ? in_bit_reg : 1'b0; //R10

	// Serial engine. Each bit: lead half at idle level, mid edge samples input,
	// trail half at active level, end edge shifts and launches the next bit.
	always_ff @(posedge LINK_CLK or posedge lrst) begin
		if (lrst) begin
			state_reg    <= tsp_pkg::LNK_IDLE;
			half_cnt_reg <= 16'h0000;
			bit_cnt_reg  <= 16'h0000;
			word_reg     <= 16'h0000;
			ldir_reg     <= 1'b0;
			lmode_reg    <= 2'h0;
			lhalf_reg    <= 16'h0000;
			lidle_reg    <= 1'b0;
			in_bit_reg   <= 1'b0;
			sclk_reg     <= 1'b0;
			done_tgl_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				tsp_pkg::LNK_IDLE: begin
					sclk_reg <= pol_lvl_reg; //R19
					if (start_evt) begin
						word_reg     <= data_reg;
						bit_cnt_reg  <= cfg.len; //R9
						ldir_reg     <= cfg.dir; //R6
						lmode_reg    <= cfg.mode; //R2
						lhalf_reg    <= half_load;
						half_cnt_reg <= half_load; //R7
						lidle_reg    <= pol_lvl_reg;
						if (cfg.len == 16'h0000) begin
							done_tgl_reg <= !done_tgl_reg;
						end else begin
							state_reg <= tsp_pkg::LNK_LEAD;
						end
					end
				end
				tsp_pkg::LNK_LEAD: begin
					if (half_end) begin
						sclk_reg     <= !lidle_reg;
						in_bit_reg   <= sdi_lvl_reg; //R18
						half_cnt_reg <= lhalf_reg;
						state_reg    <= tsp_pkg::LNK_TRAIL;
					end else begin
						half_cnt_reg <= half_cnt_reg - 16'h0001; //R7
					end
				end
				tsp_pkg::LNK_TRAIL: begin
					if (half_end) begin
						sclk_reg    <= lidle_reg;
						bit_cnt_reg <= bit_cnt_reg - 16'h0001; //R8
						if (ldir_reg) begin
							word_reg <= {word_reg[14:0], shift_in}; //R6
						end else begin
							word_reg <= {shift_in, word_reg[15:1]}; //R11
						end
						if (bit_cnt_reg == 16'h0001) begin
							done_tgl_reg <= !done_tgl_reg; //R8
							state_reg    <= tsp_pkg::LNK_IDLE;
						end else begin
							half_cnt_reg <= lhalf_reg;
							state_reg    <= tsp_pkg::LNK_LEAD;
						end
					end else begin
						half_cnt_reg <= half_cnt_reg - 16'h0001;
					end
				end
			endcase
		end
	end

	// Data out follows the word one link cycle later, so it changes just after
	// the end edge and holds through the mid edge.
	always_ff @(posedge LINK_CLK or posedge lrst) begin
		if (lrst) begin
			sdo_reg <= 1'b0;
		end else begin
			sdo_reg <= ldir_reg ? word_reg[15] : word_reg[0]; //R18
		end
	end
	// Clock channel's upper neighbour carries data out; SDI is the lower one.
	assign SCLK_O = sclk_reg;
	assign SDO_O  = sdo_reg; //R4

	property p_start_take;
		@(posedge CLK) disable iff (SYS_RST)
		(srv_reg == tsp_pkg::SRV_START && prio_reg != tsp_pkg::PRIO_OFF && !busy_reg)
			|=> (busy_reg && srv_reg == tsp_pkg::SRV_NONE);
	endproperty
	a_start_take: assert property (p_start_take) else $error("start not taken"); //R3

	property p_prio_off;
		@(posedge CLK) disable iff (SYS_RST)
		(prio_reg == tsp_pkg::PRIO_OFF) |=> $stable(start_tgl_reg);
	endproperty
	a_prio_off: assert property (p_prio_off) else $error("start while disabled"); //R15

	property p_irq_on;
		@(posedge CLK) disable iff (SYS_RST)
		(done_evt && ie_reg && $stable(ie_reg)) |-> ##2 IRQ;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missing"); //R16

	property p_irq_off;
		@(posedge CLK) disable iff (SYS_RST)
		!ie_reg |=> !IRQ;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled"); //R16

	property p_dout_free;
		@(posedge CLK) disable iff (SYS_RST)
		!mode_reg[tsp_pkg::MODE_OUT_BIT] |-> !SDO_OE;
	endproperty
	a_dout_free: assert property (p_dout_free) else $error("data out driven"); //R17

	property p_idle_clk;
		@(posedge LINK_CLK) disable iff (lrst)
		(state_reg == tsp_pkg::LNK_IDLE) ##1 (state_reg == tsp_pkg::LNK_IDLE)
			|-> SCLK_O == $past(pol_lvl_reg);
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("idle clock level"); //R19

	property p_half_hold;
		@(posedge LINK_CLK) disable iff (lrst)
		(state_reg != tsp_pkg::LNK_IDLE && !half_end) |=> $stable(SCLK_O);
	endproperty
	a_half_hold: assert property (p_half_hold) else $error("early clock edge"); //R7

	property p_bit_dec;
		@(posedge LINK_CLK) disable iff (lrst)
		(state_reg == tsp_pkg::LNK_TRAIL && half_end)
			|=> bit_cnt_reg == $past(bit_cnt_reg) - 16'h0001;
	endproperty
	a_bit_dec: assert property (p_bit_dec) else $error("bit count"); //R8

	property p_end;
		@(posedge LINK_CLK) disable iff (lrst)
		(state_reg == tsp_pkg::LNK_TRAIL && half_end && bit_cnt_reg == 16'h0001)
			|=> (state_reg == tsp_pkg::LNK_IDLE && $changed(done_tgl_reg));
	endproperty
	a_end: assert property (p_end) else $error("transfer did not end"); //R8

	property p_zero_in;
		@(posedge LINK_CLK) disable iff (lrst)
		(state_reg == tsp_pkg::LNK_TRAIL && half_end && !ldir_reg &&
		 !lmode_reg[tsp_pkg::MODE_IN_BIT]) |=> !word_reg[15];
	endproperty
	a_zero_in: assert property (p_zero_in) else $error("nonzero shifted in"); //R10

endmodule

// ---- pkg/tsp_pkg.sv ----
package tsp_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFF_CTRL = 8'h00;   // Setup, direction, mode, priority, enable, service.
	localparam logic [7:0] OFF_HALF = 8'h04;   // Half serial clock period in timer base counts.
	localparam logic [7:0] OFF_LEN  = 8'h08;   // Transfer length in bits, full 16-bit word.
	localparam logic [7:0] OFF_DATA = 8'h0c;   // Shift word.
	localparam logic [7:0] OFF_STAT = 8'h10;   // Done, busy and pending status.

	// Control register field positions.
	localparam int CTRL_SETUP_LSB = 0;         // Nine-bit channel edge setup.
	localparam int CTRL_DIR       = 9;         // Shift direction, 1 means msb first.
	localparam int CTRL_MODE_LSB  = 10;        // Two sequence mode bits.
	localparam int CTRL_PRIO_LSB  = 12;        // Two channel priority bits.
	localparam int CTRL_IE        = 14;        // Completion interrupt enable.
	localparam int CTRL_SRV_LSB   = 16;        // Two service request bits.

	// Status register field positions.
	localparam int STAT_DONE = 0;              // Sticky completion flag, write one to clear.
	localparam int STAT_BUSY = 1;              // Transfer in progress.
	localparam int STAT_PEND = 2;              // Start request waiting for a nonzero priority and for the running transfer to end.

	// Encodings.
	localparam logic [8:0] EDGE_FALL = 9'h08d;  // Data valid on the falling clock edge.
	localparam logic [8:0] EDGE_RISE = 9'h08e;  // Data valid on the rising clock edge.
	localparam logic [1:0] SRV_NONE  = 2'h0;    // No service request.
	localparam logic [1:0] SRV_START = 2'h3;    // Initialize and start a transfer.
	localparam logic [1:0] PRIO_OFF  = 2'h0;    // Channel disabled.
	localparam int MODE_OUT_BIT = 0;            // Mode bit that enables the data out channel.
	localparam int MODE_IN_BIT  = 1;            // Mode bit that enables the data in channel.

	// Reset values.
	localparam logic [8:0]  SETUP_RST = EDGE_RISE;
	localparam logic [15:0] HALF_RST  = 16'h0001;
	localparam logic [15:0] LEN_RST   = 16'h0008;
	localparam logic [15:0] DATA_RST  = 16'h0000;

	// Synchroniser depth for inputs from another domain.
	localparam int SYNC_STAGES = 3;

	// Transfer settings handed to the link domain at start.
	typedef struct packed {
		logic [15:0] half;                     // Half period count.
		logic [15:0] len;                      // Bit count.
		logic        dir;                      // Msb first when set.
		logic [1:0]  mode;                     // Sequence mode bits.
	} tsp_cfg_t;

	// Link engine states.
	typedef enum logic [2:0] {
		LNK_IDLE  = 3'b001,                    // Clock at idle level.
		LNK_LEAD  = 3'b010,                    // First half of a bit.
		LNK_TRAIL = 3'b100                     // Second half of a bit.
	} tsp_lnk_state_t;

endpackage

// ---- sim/tsp_slave_model.sv ----
`timescale 1ns/1ps
// Far-side serial slave: it only follows the clock that the master makes.
module tsp_slave_model (
	input  wire logic        sclk,  // Serial clock from the master.
	input  wire logic        sdo,   // Data from the master.
	input  wire logic        idle,  // Idle clock level for the chosen polarity.
	input  wire logic        clr,   // Restarts the bit index before a frame.
	input  wire logic [15:0] seq,   // Bits to send, in index order.
	output logic             sdi,   // Data back to the master.
	output int               n,     // Bits clocked so far.
	output logic [15:0]      got    // Bits captured, in index order.
);
	// Capture on the leading edge and move on at the trailing edge, so data
	// is stable for a whole half period around the master's sample point.
	always @(sclk or posedge clr) begin
		if (clr) begin
			n = 0;
			sdi = seq[0];
		end else if (sclk !== idle) begin
			got[n[3:0]] = sdo;
		end else begin
			n = n + 1;
			sdi = seq[n[3:0]];
		end
	end
endmodule

// ---- sim/tsp_top_tb.sv ----
`timescale 1ns/1ps
module tsp_top_tb;
	logic        clk, sys_rst, link_clk, psel, penable, pwrite, sdi, clr, idle;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, sclk_o, sclk_oe, sdo_o, sdo_oe, irq;
	logic [15:0] seq, got;
	logic [33:0] note;      // Oldest read note: check flag, error, data.
	logic [33:0] expq[$];   // Read notes in issue order.
	int          n_bits, n_errors, tests_run, s;

	tsp_top DUT (.CLK(clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCLK_O(sclk_o),
		.SCLK_OE(sclk_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SDI(sdi), .IRQ(irq));
	tsp_slave_model slave (.sclk(sclk_o), .sdo(sdo_o), .idle(idle), .clr(clr),
		.seq(seq), .sdi(sdi), .n(n_bits), .got(got));

	// Bus clock at 25 MHz, link clock at 48 ns with an unrelated phase.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end

	// Counts and reports one comparison.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic test_done;
		$display("Checks %0d, errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; a read leaves its note for the monitor.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic c, input logic [32:0] e);
		if (!w) begin
			expq.push_back({c, e});
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog may end a wait for the slave's answer.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Read data and the error flag are taken at the edge that completes a read.
	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			note = expq.pop_front();
			if (note[33]) begin
				chk(prdata, note[31:0]);
				chk(32'(pslverr), 32'(note[32]));
			end
		end
	end

	// One whole transfer, started in the documented host order.
	task automatic run(input logic [1:0] m, input logic dr, input logic fl,
		input logic [15:0] len, input logic ie);
		logic [15:0] w;
		logic [8:0]  st;
		logic        b;
		int          i;
		w = 16'($urandom);
		st = fl ? tsp_pkg::EDGE_FALL : tsp_pkg::EDGE_RISE;
		seq <= 16'($urandom);
		idle <= fl;
		apb(1'b1, tsp_pkg::OFF_CTRL, {20'h0, m, dr, st}, 1'b0, 33'h0);
		apb(1'b1, tsp_pkg::OFF_HALF, 32'h6, 1'b0, 33'h0);
		apb(1'b1, tsp_pkg::OFF_LEN, {16'h0, len}, 1'b0, 33'h0);
		apb(1'b1, tsp_pkg::OFF_DATA, {16'h0, w}, 1'b0, 33'h0);
		repeat (10) @(posedge clk);
		chk(32'(sclk_o), 32'(fl));
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		apb(1'b1, tsp_pkg::OFF_CTRL, {14'h0, 2'b11, 1'b0, ie, 2'b00, m, dr, st}, 1'b0, 33'h0);
		apb(1'b0, tsp_pkg::OFF_STAT, 32'h0, 1'b1, 33'h4);
		apb(1'b1, tsp_pkg::OFF_CTRL, {14'h0, 2'b11, 1'b0, ie, 2'b01, m, dr, st}, 1'b0, 33'h0);
		i = 0;
		while (n_bits < int'(len) && i < 5000) begin
			@(posedge clk);
			i++;
		end
		repeat (20) @(posedge clk);
		chk(n_bits, 32'(len));
		chk(32'(irq), 32'(ie));
		chk({30'h0, sclk_oe, sdo_oe}, {30'h0, 1'b1, m[0]});
		// Work out what the slave saw and what the shift word must hold.
		for (i = 0; i < int'(len); i++) begin
			b = m[1] ? seq[i[3:0]] : 1'b0;
			if (m[0]) begin
				chk(32'(got[i[3:0]]), 32'(dr ? w[15] : w[0]));
			end
			w = dr ? {w[14:0], b} : {b, w[15:1]};
		end
		apb(1'b0, tsp_pkg::OFF_DATA, 32'h0, 1'b1, {17'h0, w});
		apb(1'b0, tsp_pkg::OFF_STAT, 32'h0, 1'b1, 33'h1);
		apb(1'b1, tsp_pkg::OFF_STAT, 32'h1, 1'b0, 33'h0);
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h0);
	endtask

	// Watchdog well past the expected run length.
	initial begin
		#2000000;
		n_errors++;
		test_done;
	end

	// Main sequence.
	initial begin
		logic [7:0]  ra[5];
		logic [31:0] rv[5];
		ra = '{tsp_pkg::OFF_CTRL, tsp_pkg::OFF_HALF, tsp_pkg::OFF_LEN, tsp_pkg::OFF_DATA,
			tsp_pkg::OFF_STAT};
		rv = '{32'h8e, 32'h1, 32'h8, 32'h0, 32'h0};
		{psel, penable, pwrite, clr, idle} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seq = 16'h0;
		tests_run = 0;
		n_errors = 0;
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		void'($urandom(34));
		repeat (3) @(posedge clk);
		for (s = 0; s < 5; s++) begin
			apb(1'b0, ra[s], 32'h0, 1'b1, {1'b0, rv[s]});
		end
		apb(1'b0, 8'h14, 32'h0, 1'b1, 33'h100000000);
		// Codes 01 and 10 must leave the engine alone.
		for (s = 1; s < 3; s++) begin
			apb(1'b1, tsp_pkg::OFF_CTRL, {14'h0, 2'(s), 4'h1, 12'h08e}, 1'b0, 33'h0);
			apb(1'b0, tsp_pkg::OFF_STAT, 32'h0, 1'b1, 33'h0);
		end
		for (s = 0; s < 8; s++) begin
			run(2'(s >> 1), s[0], 1'($urandom), 16'(1 + $urandom % 16), s[0]);
		end
		run(2'b00, 1'b0, 1'b1, 16'd20, 1'b1);
		// A zero length must finish at once with no clocks and an untouched word.
		run(2'b11, 1'b1, 1'b0, 16'd0, 1'b1);
		test_done;
	end
endmodule
